// file: rtl/i2ad_pkg.sv
// Constants shared by the abort flag and DMA request logic
package i2ad_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [31:0] ADDR_DMA_CONTROL = 32'h50020388;
    localparam logic [31:0] ADDR_DMA_TX_LEVEL = 32'h5002038c;
    localparam logic [31:0] ADDR_DMA_RX_LEVEL = 32'h50020390;
    localparam logic [31:0] ADDR_ABORT_STATUS = 32'h500203a0;
    localparam logic [31:0] ADDR_ABORT_MASK = 32'h500203a4;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int BIT_RX_DMA_ENABLE = 0;
    localparam int BIT_TX_DMA_ENABLE = 1;
    localparam int DMA_CTL_W = 2;
    localparam int LEVEL_W = 5;
    localparam int REG_W = 16;
    localparam logic [DMA_CTL_W-1:0] RST_DMA_CONTROL = 2'h0;
    localparam logic [LEVEL_W-1:0] RST_TX_LEVEL = 5'h00;
    localparam logic [LEVEL_W-1:0] RST_RX_LEVEL = 5'h00;

    // Abort cause bits
    localparam int ABORT_W = 5;
    localparam int BIT_ABORT_SHORT_ADDR = 0;
    localparam int BIT_ABORT_WIDE_FIRST = 1;
    localparam int BIT_ABORT_WIDE_SECOND = 2;
    localparam int BIT_ABORT_DATA = 3;
    localparam int BIT_ABORT_GCALL = 4;
    localparam logic [ABORT_W-1:0] RST_ABORT_STATUS = 5'h00;
    localparam logic [ABORT_W-1:0] RST_ABORT_MASK = 5'h00;

    // Acknowledge slot phase, one-hot, reported by the protocol engine
    localparam logic [3:0] PH_ADDR_FIRST = 4'h1;
    localparam logic [3:0] PH_ADDR_SECOND = 4'h2;
    localparam logic [3:0] PH_GCALL = 4'h4;
    localparam logic [3:0] PH_DATA = 4'h8;

endpackage : i2ad_pkg

// file: rtl/i2ad_core_if.sv
// Interface joining register block, abort classifier and DMA request logic
`timescale 1ns/10ps
interface i2ad_core_if #(
    parameter int CNT_W = 6
);
    import i2ad_pkg::*;
    logic tx_en;
    logic rx_en;
    logic [LEVEL_W-1:0] tx_lvl;
    logic [LEVEL_W-1:0] rx_lvl;
    logic [CNT_W-1:0] tx_cnt;
    logic [CNT_W-1:0] rx_cnt;
    logic tx_req;
    logic rx_req;
    logic ack_slot;
    logic ack_nack;
    logic [3:0] ack_phase;
    logic master_mode;
    logic master_tx;
    logic wide_addr;
    logic [ABORT_W-1:0] abort_evt;

    modport regs (output tx_en, rx_en, tx_lvl, rx_lvl, tx_cnt, rx_cnt, ack_slot, ack_nack,
                  ack_phase, master_mode, master_tx, wide_addr,
                  input tx_req, rx_req, abort_evt);
    modport dma (input tx_en, rx_en, tx_lvl, rx_lvl, tx_cnt, rx_cnt, output tx_req, rx_req);
    modport cls (input ack_slot, ack_nack, ack_phase, master_mode, master_tx, wide_addr,
                 output abort_evt);
endinterface : i2ad_core_if

// file: rtl/i2ad_abort_cls.sv
// Classifier turning missed acknowledges into abort cause events
`timescale 1ns/10ps
module i2ad_abort_cls
    import i2ad_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    i2ad_core_if.cls cif
);

    typedef struct packed {
        logic [ABORT_W-1:0] evt;
    } i2ad_cls_s;

    i2ad_cls_s st_ff;
    i2ad_cls_s nxt_st;
    logic miss;

    always_comb begin
        nxt_st = '0;
        miss = cif.ack_slot & cif.ack_nack & cif.master_mode;
        if (miss) begin
            unique case (cif.ack_phase)
                PH_GCALL: nxt_st.evt[BIT_ABORT_GCALL] = cif.master_tx;
                PH_DATA: nxt_st.evt[BIT_ABORT_DATA] = cif.master_tx;
                PH_ADDR_SECOND: nxt_st.evt[BIT_ABORT_WIDE_SECOND] = cif.wide_addr;
                PH_ADDR_FIRST: begin
                    nxt_st.evt[BIT_ABORT_WIDE_FIRST] = cif.wide_addr;
                    nxt_st.evt[BIT_ABORT_SHORT_ADDR] = ~cif.wide_addr;
                end
                // Phase code comes from outside; ignore anything not one-hot
                default: nxt_st.evt = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign cif.abort_evt = st_ff.evt;

endmodule : i2ad_abort_cls

// file: rtl/i2ad_dma_req.sv
// Watermark comparison for transmit and receive DMA requests
`timescale 1ns/10ps
module i2ad_dma_req
    import i2ad_pkg::*;
#(
    parameter int CNT_W = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    i2ad_core_if.dma dif
);

    typedef struct packed {
        logic tx_req;
        logic rx_req;
    } i2ad_dma_s;

    i2ad_dma_s st_ff;
    i2ad_dma_s nxt_st;
    logic [CNT_W-1:0] tx_mark;
    logic [CNT_W-1:0] rx_mark;

    always_comb begin
        tx_mark = CNT_W'(dif.tx_lvl);
        rx_mark = CNT_W'(dif.rx_lvl) + CNT_W'(1);
        nxt_st.tx_req = dif.tx_en & (dif.tx_cnt <= tx_mark);
        nxt_st.rx_req = dif.rx_en & (dif.rx_cnt >= rx_mark);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign dif.tx_req = st_ff.tx_req;
    assign dif.rx_req = st_ff.rx_req;

endmodule : i2ad_dma_req

// file: rtl/i2ad_top.sv
// APB register block for I2C abort causes and DMA request generation
//
// Summary of operation
// - As master transmitter, set general-call abort flag when nobody acknowledges it.
// - As master transmitter, set bit 3 when a data byte is not acknowledged.
// - Wide addressing, set bit 2 when second address byte is not acknowledged.
// - Wide addressing, set bit 1 when first address byte is not acknowledged.
// - Short addressing, set bit 0 when the address is not acknowledged.
// - Control bit 1 enables transmit DMA, read-write, resets to zero.
// - Control bit 0 enables receive DMA, read-write, resets to zero.
// - Transmit request while enabled and transmit count at or below 5-bit level.
// - Receive request while enabled and receive count at least level plus one.
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
module i2ad_top
    import i2ad_pkg::*;
#(
    parameter int CNT_W = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ack_slot,
    input wire logic ack_nack,
    input wire logic [3:0] ack_phase,
    input wire logic master_mode,
    input wire logic master_tx,
    input wire logic wide_addr,
    input wire logic [CNT_W-1:0] tx_fifo_count,
    input wire logic [CNT_W-1:0] rx_fifo_count,
    output logic dma_tx_req,
    output logic dma_rx_req,
    output logic xfer_abort,
    output logic irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [DMA_CTL_W-1:0] dma_ctl;
        logic [LEVEL_W-1:0] tx_lvl;
        logic [LEVEL_W-1:0] rx_lvl;
        logic [ABORT_W-1:0] abort_st;
        logic [ABORT_W-1:0] abort_mask;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic xfer_abort;
        logic dma_tx_req;
        logic dma_rx_req;
    } i2ad_top_s;

    i2ad_top_s st_ff;
    i2ad_top_s nxt_st;

    i2ad_core_if #(.CNT_W(CNT_W)) core_if ();

    // ------------------------------------------------------------------
    // Sub-blocks
    // ------------------------------------------------------------------
    i2ad_abort_cls u_cls (
        .pclk(pclk),
        .presetn(presetn),
        .cif(core_if.cls)
    );

    i2ad_dma_req #(.CNT_W(CNT_W)) u_dma (
        .pclk(pclk),
        .presetn(presetn),
        .dif(core_if.dma)
    );

    // Engine inputs share pclk, so they go straight through
    assign core_if.ack_slot = ack_slot;
    assign core_if.ack_nack = ack_nack;
    assign core_if.ack_phase = ack_phase;
    assign core_if.master_mode = master_mode;
    assign core_if.master_tx = master_tx;
    assign core_if.wide_addr = wide_addr;
    assign core_if.tx_cnt = tx_fifo_count;
    assign core_if.rx_cnt = rx_fifo_count;
    assign core_if.tx_en = st_ff.dma_ctl[BIT_TX_DMA_ENABLE];
    assign core_if.rx_en = st_ff.dma_ctl[BIT_RX_DMA_ENABLE];
    assign core_if.tx_lvl = st_ff.tx_lvl;
    assign core_if.rx_lvl = st_ff.rx_lvl;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic setup_ph;
    logic access_done;
    logic wr_en;
    logic hit_ctl;
    logic hit_txl;
    logic hit_rxl;
    logic hit_ast;
    logic hit_amk;
    logic hit_any;
    logic [31:0] rd_word;
    logic [ABORT_W-1:0] clr_bits;
    logic [ABORT_W-1:0] set_bits;

    always_comb begin
        setup_ph = psel & ~penable;
        // Write lands only on the edge that completes the access phase
        access_done = psel & penable & st_ff.pready;
        wr_en = access_done & pwrite;
        hit_ctl = (paddr == ADDR_DMA_CONTROL);
        hit_txl = (paddr == ADDR_DMA_TX_LEVEL);
        hit_rxl = (paddr == ADDR_DMA_RX_LEVEL);
        hit_ast = (paddr == ADDR_ABORT_STATUS);
        hit_amk = (paddr == ADDR_ABORT_MASK);
        hit_any = hit_ctl | hit_txl | hit_rxl | hit_ast | hit_amk;
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd_word = 32'h00000000;
        if (hit_ctl) begin
            rd_word[DMA_CTL_W-1:0] = st_ff.dma_ctl;
        end
        if (hit_txl) begin
            rd_word[LEVEL_W-1:0] = st_ff.tx_lvl;
        end
        if (hit_rxl) begin
            rd_word[LEVEL_W-1:0] = st_ff.rx_lvl;
        end
        if (hit_ast) begin
            rd_word[ABORT_W-1:0] = st_ff.abort_st;
        end
        if (hit_amk) begin
            rd_word[ABORT_W-1:0] = st_ff.abort_mask;
        end
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;

        // Bus answer: one wait-free access phase after every setup cycle
        nxt_st.pready = setup_ph;
        nxt_st.pslverr = setup_ph & ~hit_any;
        if (setup_ph) begin
            nxt_st.prdata = (pwrite || !hit_any) ? 32'h00000000 : rd_word;
        end

        // Register writes
        if (wr_en && hit_ctl) begin
            nxt_st.dma_ctl[BIT_TX_DMA_ENABLE] = pwdata[BIT_TX_DMA_ENABLE];
            nxt_st.dma_ctl[BIT_RX_DMA_ENABLE] = pwdata[BIT_RX_DMA_ENABLE];
        end
        if (wr_en && hit_txl) begin
            nxt_st.tx_lvl = pwdata[LEVEL_W-1:0];
        end
        if (wr_en && hit_rxl) begin
            nxt_st.rx_lvl = pwdata[LEVEL_W-1:0];
        end
        if (wr_en && hit_amk) begin
            nxt_st.abort_mask = pwdata[ABORT_W-1:0];
        end

        // Sticky causes; a fresh event beats a same-cycle clear
        clr_bits = (wr_en && hit_ast) ? pwdata[ABORT_W-1:0] : '0;
        set_bits = core_if.abort_evt;
        nxt_st.abort_st = (st_ff.abort_st & ~clr_bits) | set_bits;

        // Transfer stays halted until every cause is cleared
        nxt_st.xfer_abort = |nxt_st.abort_st;
        nxt_st.irq = |(nxt_st.abort_st & st_ff.abort_mask);

        nxt_st.dma_tx_req = core_if.tx_req;
        nxt_st.dma_rx_req = core_if.rx_req;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff.dma_ctl <= RST_DMA_CONTROL;
            st_ff.tx_lvl <= RST_TX_LEVEL;
            st_ff.rx_lvl <= RST_RX_LEVEL;
            st_ff.abort_st <= RST_ABORT_STATUS;
            st_ff.abort_mask <= RST_ABORT_MASK;
            st_ff.prdata <= 32'h00000000;
            st_ff.pready <= 1'b0;
            st_ff.pslverr <= 1'b0;
            st_ff.irq <= 1'b0;
            st_ff.xfer_abort <= 1'b0;
            st_ff.dma_tx_req <= 1'b0;
            st_ff.dma_rx_req <= 1'b0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Requests gain one register stage here so every port leaves a flop
    assign prdata = st_ff.prdata;
    assign pready = st_ff.pready;
    assign pslverr = st_ff.pslverr;
    assign irq = st_ff.irq;
    assign xfer_abort = st_ff.xfer_abort;
    assign dma_tx_req = st_ff.dma_tx_req;
    assign dma_rx_req = st_ff.dma_rx_req;

endmodule : i2ad_top

// file: verif/i2ad_far_model.sv
// Model of the protocol engine and FIFO counters facing the block
`timescale 1ns/10ps
module i2ad_far_model
    import i2ad_pkg::*;
#(
    parameter int CNT_W = 6
) (
    input wire logic pclk,
    output logic ack_slot,
    output logic ack_nack,
    output logic [3:0] ack_phase,
    output logic master_mode,
    output logic master_tx,
    output logic wide_addr,
    output logic [CNT_W-1:0] tx_fifo_count,
    output logic [CNT_W-1:0] rx_fifo_count
);
    initial begin
        {ack_slot, ack_nack, ack_phase, master_mode, master_tx, wide_addr} = '0;
        tx_fifo_count = '0;
        rx_fifo_count = '0;
    end
    // Phase inverted after the slot so a stale value never looks valid
    task automatic slot(input logic [3:0] ph, input logic wd, input logic mtx, input logic mm);
        @(posedge pclk);
        {ack_slot, ack_nack, ack_phase} <= {2'b11, ph};
        {wide_addr, master_tx, master_mode} <= {wd, mtx, mm};
        @(posedge pclk);
        {ack_slot, ack_nack, ack_phase, master_mode} <= {2'b00, ~ph, 1'b0};
    endtask : slot
    task automatic counts(input logic [CNT_W-1:0] t, input logic [CNT_W-1:0] r);
        @(posedge pclk);
        tx_fifo_count <= t;
        rx_fifo_count <= r;
    endtask : counts
endmodule : i2ad_far_model

// file: verif/i2ad_chk.sv
// Port checker for abort flags, DMA requests and bus timing
`timescale 1ns/10ps
module i2ad_chk
    import i2ad_pkg::*;
#(
    parameter int CNT_W = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic ack_slot,
    input wire logic ack_nack,
    input wire logic [3:0] ack_phase,
    input wire logic master_mode,
    input wire logic master_tx,
    input wire logic wide_addr,
    input wire logic [CNT_W-1:0] tx_fifo_count,
    input wire logic [CNT_W-1:0] rx_fifo_count,
    input wire logic dma_tx_req,
    input wire logic dma_rx_req,
    input wire logic xfer_abort,
    input wire logic irq
);
    // ------------------------------------------------------------
    // Shadow of control and levels, rebuilt from bus writes
    // ------------------------------------------------------------
    logic [11:0] sh_ff;
    logic wr, wclr, nk, txc, rxc;
    assign wr = psel && penable && pwrite && pready;
    assign wclr = psel && penable && pwrite && paddr == ADDR_ABORT_STATUS;
    assign nk = ack_slot && ack_nack && master_mode;
    assign txc = sh_ff[11] && tx_fifo_count <= CNT_W'(sh_ff[9:5]);
    assign rxc = sh_ff[10] && rx_fifo_count > CNT_W'(sh_ff[4:0]);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_ff <= '0;
        end else if (wr && paddr == ADDR_DMA_CONTROL) begin
            sh_ff[11:10] <= pwdata[1:0];
        end else if (wr && paddr == ADDR_DMA_TX_LEVEL) begin
            sh_ff[9:5] <= pwdata[4:0];
        end else if (wr && paddr == ADDR_DMA_RX_LEVEL) begin
            sh_ff[4:0] <= pwdata[4:0];
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    bus_ready_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    bus_err_a: assert property (pslverr |-> pready) else $error("error without ready");
    ctl_read_a: assert property (psel && penable && !pwrite && pready &&
        paddr == ADDR_DMA_CONTROL |-> prdata == {30'h0, sh_ff[11:10]})
        else $error("control readback wrong");
    tx_req_a: assert property (dma_tx_req == $past(txc, 2))
        else $error("tx request wrong");
    rx_req_a: assert property (dma_rx_req == $past(rxc, 2))
        else $error("rx request wrong");
    addr_abort_a: assert property (nk && (ack_phase == PH_ADDR_FIRST ||
        ack_phase == PH_ADDR_SECOND && wide_addr) |-> ##2 xfer_abort)
        else $error("address abort missed");
    tx_abort_a: assert property (nk && master_tx &&
        (ack_phase == PH_DATA || ack_phase == PH_GCALL) |-> ##2 xfer_abort)
        else $error("transmit abort missed");
    abort_cause_a: assert property ($rose(xfer_abort) |-> $past(nk, 2))
        else $error("abort without cause");
    abort_hold_a: assert property (xfer_abort && !wclr && !$past(wclr) |=> xfer_abort)
        else $error("abort dropped");
    irq_gate_a: assert property (irq |-> xfer_abort) else $error("irq without abort");
    cover property (dma_tx_req && dma_rx_req);
    cover property ($rose(xfer_abort) ##3 irq);
    cover property (pslverr);
endmodule : i2ad_chk
bind i2ad_top i2ad_chk #(.CNT_W(CNT_W)) u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ack_slot, .ack_nack, .ack_phase,
    .master_mode, .master_tx, .wide_addr, .tx_fifo_count, .rx_fifo_count, .dma_tx_req,
    .dma_rx_req, .xfer_abort, .irq);

// file: verif/tb_i2c_abort_flags_and_dma_requests.sv
// Self-checking bench for abort flags and DMA requests
`timescale 1ns/10ps
module tb_i2c_abort_flags_and_dma_requests;
    import i2ad_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, ack_slot, ack_nack, master_mode, master_tx, wide_addr;
    logic [3:0] ack_phase;
    logic [5:0] tx_fifo_count, rx_fifo_count;
    logic dma_tx_req, dma_rx_req, xfer_abort, irq;
    int fails = 0;
    int n_compared = 0;
    // Phase, wide, master_tx, master_mode, expected status
    logic [11:0] ab_rows [8] = '{12'h161, 12'h1a2, 12'h2a4, 12'h868, 12'h470, 12'h820,
        12'h420, 12'h140};
    // Control, tx count, rx count, expected requests; levels tx 4, rx 2
    logic [15:0] dm_rows [5] = '{16'hc40f, 16'hc508, 16'h807e, 16'h7f0d, 16'h00fc};
    always #5 pclk = ~pclk;
    i2ad_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ack_slot, .ack_nack, .ack_phase, .master_mode, .master_tx,
        .wide_addr, .tx_fifo_count, .rx_fifo_count, .dma_tx_req, .dma_rx_req, .xfer_abort,
        .irq);
    i2ad_far_model far (.pclk, .ack_slot, .ack_nack, .ack_phase, .master_mode, .master_tx,
        .wide_addr, .tx_fifo_count, .rx_fifo_count);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // Request held until the rising edge that sees pready; data taken at that edge only
    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, err} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    task automatic end_of_test();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, ADDR_ABORT_MASK, 32'h1f);
        for (int i = 0; i < 8; i++) begin
            far.slot(ab_rows[i][11:8], ab_rows[i][7], ab_rows[i][6], ab_rows[i][5]);
            repeat (3) @(posedge pclk);
            rdchk(ADDR_ABORT_STATUS, {27'h0, ab_rows[i][4:0]});
            chk({xfer_abort, irq}, {2{|ab_rows[i][4:0]}});
            apb(1'b1, ADDR_ABORT_STATUS, 32'h1f);
            rdchk(ADDR_ABORT_STATUS, 32'h0);
        end
        apb(1'b1, ADDR_DMA_TX_LEVEL, 32'hffff_ffe4);
        rdchk(ADDR_DMA_TX_LEVEL, 32'h4);
        apb(1'b1, ADDR_DMA_RX_LEVEL, 32'h2);
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, ADDR_DMA_CONTROL, {30'h0, dm_rows[i][15:14]});
            rdchk(ADDR_DMA_CONTROL, {30'h0, dm_rows[i][15:14]});
            far.counts(dm_rows[i][13:8], dm_rows[i][7:2]);
            repeat (3) @(posedge pclk);
            chk({dma_tx_req, dma_rx_req}, dm_rows[i][1:0]);
        end
        // Masked cause stays off the interrupt until its mask bit is set
        apb(1'b1, ADDR_ABORT_MASK, 32'h08);
        far.slot(PH_GCALL, 1'b0, 1'b1, 1'b1);
        repeat (3) @(posedge pclk);
        chk({xfer_abort, irq}, 32'h2);
        apb(1'b1, ADDR_ABORT_MASK, 32'h10);
        repeat (2) @(posedge pclk);
        chk({xfer_abort, irq}, 32'h3);
        apb(1'b0, 32'h50020394, 32'h0);
        chk(rd, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, ADDR_DMA_CONTROL, 32'h3);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(ADDR_DMA_CONTROL, 32'h0);
        rdchk(ADDR_DMA_TX_LEVEL, 32'h0);
        rdchk(ADDR_ABORT_STATUS, 32'h0);
        chk({dma_tx_req, dma_rx_req, xfer_abort, irq}, 32'h0);
        end_of_test();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (3000) @(posedge pclk);
        fails++;
        end_of_test();
    end
endmodule : tb_i2c_abort_flags_and_dma_requests
